// ===== core/fcf_pkg.sv
// constants for the fault control and flag register bank
package fcf_pkg;
    // register addresses as seen over the two-wire bus
    localparam logic [7:0] FAULT_CTRL_ADDR = 8'h1E;
    localparam logic [7:0] FAULT_FLAGS_ADDR = 8'h1F;
    // fault_response_control field layout
    localparam int CTRL_WIDTH = 4;
    localparam int CTRL_PAD = 4;
    localparam int CTRL_SHORT_EN = 3;
    localparam int CTRL_THERMAL_KEEP = 2;
    localparam int CTRL_CURRENT_KEEP = 1;
    localparam int CTRL_VOLTAGE_KEEP = 0;
    localparam logic [3:0] CTRL_RESET = 4'h7;
    // fault_status_flags field layout
    localparam int FLAG_WIDTH = 5;
    localparam int FLAG_PAD = 3;
    localparam int FLAG_OPEN = 4;
    localparam int FLAG_SHORT = 3;
    localparam int FLAG_THERMAL = 2;
    localparam int FLAG_CURRENT = 1;
    localparam int FLAG_VOLTAGE = 0;
    localparam logic [4:0] FLAG_RESET = 5'h00;
    // byte framing on the bus
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_COUNT_ONE = 4'h1;
    localparam logic [7:0] ADDR_STEP = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [6:0] CHIP_ADDR_ZERO = 7'h00;
endpackage

// ===== core/fcf_flag_if.sv
// carrier between the bus/control logic and the sticky flag store
`timescale 1ns/1ps
`default_nettype none
interface fcf_flag_if;
    logic [fcf_pkg::FLAG_WIDTH-1:0] detect; // raw fault events, level per cycle
    logic clearReq; // one-cycle pulse, status register was read
    logic [fcf_pkg::FLAG_WIDTH-1:0] flags; // held fault flags
    logic [fcf_pkg::CTRL_SHORT_EN-1:0] keep; // shutdown keep bits of the control register
    logic shutdown; // latched forced shutdown

    // flag store side
    modport store (input detect, input clearReq, input keep, output flags, output shutdown);
    // control side
    modport ctl (output detect, output clearReq, output keep, input flags, input shutdown);
endinterface
`default_nettype wire

// ===== core/fcf_flag_store.sv
// sticky fault flags, cleared by a status read, and the forced shutdown latch
`timescale 1ns/1ps
`default_nettype none
module fcf_flag_store #(
    parameter int NUM_FLAGS = fcf_pkg::FLAG_WIDTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic swReset,
    fcf_flag_if.store flagIf
);
    // the store is sized to the status register field
    if (NUM_FLAGS != fcf_pkg::FLAG_WIDTH)
    begin : gBadWidth
        $error("flag store width must match the status field");
    end

    logic [NUM_FLAGS-1:0] flags_q; // held flags
    logic [NUM_FLAGS-1:0] flags_d; // next flags
    logic clearReq_q; // status read pulse, one cycle after the byte load
    logic shutdown_q; // latched forced shutdown
    logic tripNow; // an unmasked flag is held

    // status read clears the flags one cycle after the byte is loaded
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clearReq_q <= 1'b0;
        end
        else if (clkEn)
        begin
            clearReq_q <= flagIf.clearReq; // see RULE7
        end
    end

    // event set beats a read clear in the same cycle
    always_comb
    begin
        flags_d = flags_q; // hold by default
        if (clearReq_q)
        begin
            flags_d = '0; // see RULE7
        end
        flags_d = flags_d | flagIf.detect; // see RULE4
    end

    // flag register, frozen while clock enable is low
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_q <= fcf_pkg::FLAG_RESET;
        end
        else if (clkEn)
        begin
            if (swReset)
            begin
                flags_q <= fcf_pkg::FLAG_RESET; // software reset
            end
            else
            begin
                flags_q <= flags_d; // see RULE7
            end
        end
    end

    // unmasked thermal, current or voltage/open flag; bit 0 keeps the last two
    assign tripNow =
        (flags_q[fcf_pkg::FLAG_THERMAL] && !flagIf.keep[fcf_pkg::CTRL_THERMAL_KEEP]) ||
        (flags_q[fcf_pkg::FLAG_CURRENT] && !flagIf.keep[fcf_pkg::CTRL_CURRENT_KEEP]) ||
        ((flags_q[fcf_pkg::FLAG_VOLTAGE] || flags_q[fcf_pkg::FLAG_OPEN]) &&
         !flagIf.keep[fcf_pkg::CTRL_VOLTAGE_KEEP]); // see RULE2

    // forced shutdown latches until reset once an unmasked flag is held
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shutdown_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (swReset)
            begin
                shutdown_q <= 1'b0; // software reset
            end
            else if (tripNow)
            begin
                shutdown_q <= 1'b1; // see RULE2
            end
        end
    end

    assign flagIf.flags = flags_q;
    assign flagIf.shutdown = shutdown_q;
endmodule // fcf_flag_store
`default_nettype wire

// ===== core/fcf_fault_bank.sv
// fault control and flag registers behind a two-wire serial slave
// Contract
// RULE1 - short detection runs only when bit 3 set
// RULE2 - cleared keep bit plus flag forces shutdown
// RULE3 - keep bits reset to one, run on
// RULE4 - status bits report open, short, thermal, current, voltage
// RULE5 - reserved bit positions read back as zero
// RULE6 - host sends address, register, then data byte
// RULE7 - flags stay set until status read or reset
`timescale 1ns/1ps
`default_nettype none
module fcf_fault_bank (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic swReset,
    input wire logic [6:0] chipAddr,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic openStringDetect,
    input wire logic ledShortDetect,
    input wire logic thermalTripDetect,
    input wire logic overcurrentGuardDetect,
    input wire logic overvoltageGuardDetect,
    output logic shortDetectEnable,
    output logic forceShutdown,
    output logic [4:0] faultFlags
);
    // serial slave states
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK,
        S_WRITE, S_WRITE_ACK, S_READ, S_READ_ACK
    } fcf_state_t;

    fcf_state_t state_q; // bus state
    logic sclPrev_q; // last scl sample
    logic sdaPrev_q; // last sda sample
    logic [3:0] bitCnt_q; // bits seen in current byte
    logic [7:0] shift_q; // received byte
    logic [7:0] tx_q; // byte being sent
    logic [7:0] ptr_q; // register pointer
    logic readMode_q; // read requested in address byte
    logic masterAck_q; // master acked last read byte
    logic sdaOe_q; // pulling sda low
    logic [3:0] ctrl_q; // fault_response_control
    logic writeStb; // register write this cycle
    logic loadStb; // read byte load this cycle
    logic sclRise; // scl rising edge
    logic sclFall; // scl falling edge
    logic startSeen; // start or repeated start
    logic stopSeen; // stop condition
    logic byteFull; // eight bits taken
    logic [2:0] txIdx; // next bit to drive
    logic [7:0] readByte; // addressed register contents

    fcf_flag_if flagIf ();

    // register read mux, unmapped addresses read zero
    function automatic logic [7:0] readReg(input logic [7:0] a, input logic [3:0] c,
                                           input logic [4:0] f);
        case (a)
            fcf_pkg::FAULT_CTRL_ADDR: readReg = {{fcf_pkg::CTRL_PAD{1'b0}}, c}; // see RULE5
            fcf_pkg::FAULT_FLAGS_ADDR: readReg = {{fcf_pkg::FLAG_PAD{1'b0}}, f}; // see RULE5
            default: readReg = fcf_pkg::BYTE_ZERO;
        endcase
    endfunction

    // bus edge and condition detection on synchronous pins
    assign sclRise = scl & ~sclPrev_q;
    assign sclFall = ~scl & sclPrev_q;
    assign startSeen = scl & sclPrev_q & sdaPrev_q & ~sdaIn;
    assign stopSeen = scl & sclPrev_q & ~sdaPrev_q & sdaIn;
    assign byteFull = (bitCnt_q == fcf_pkg::BITS_PER_BYTE);
    assign txIdx = 3'(fcf_pkg::BITS_PER_BYTE - fcf_pkg::BIT_COUNT_ONE - bitCnt_q);
    assign readByte = readReg(ptr_q, ctrl_q, flagIf.flags);
    assign writeStb = (state_q == S_WRITE) && sclFall && byteFull && !startSeen && !stopSeen;
    assign loadStb = sclFall && !startSeen && !stopSeen &&
                     (((state_q == S_ADDR_ACK) && readMode_q) ||
                      ((state_q == S_READ_ACK) && masterAck_q));

    // pin history for edge detection
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else if (clkEn)
        begin
            sclPrev_q <= scl;
            sdaPrev_q <= sdaIn;
        end
    end

    // serial slave: address, register, data bytes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_IDLE;
            bitCnt_q <= fcf_pkg::BIT_COUNT_ZERO;
            shift_q <= fcf_pkg::BYTE_ZERO;
            tx_q <= fcf_pkg::BYTE_ZERO;
            readMode_q <= 1'b0;
            masterAck_q <= 1'b0;
            sdaOe_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (swReset || stopSeen)
            begin
                state_q <= S_IDLE; // bus released
                sdaOe_q <= 1'b0;
            end
            else if (startSeen)
            begin
                state_q <= S_ADDR; // see RULE6
                bitCnt_q <= fcf_pkg::BIT_COUNT_ZERO;
                sdaOe_q <= 1'b0;
            end
            else
            begin
                // sample incoming bits on rising scl
                if (sclRise && (state_q == S_ADDR || state_q == S_REG || state_q == S_WRITE))
                begin
                    shift_q <= {shift_q[6:0], sdaIn};
                    bitCnt_q <= bitCnt_q + fcf_pkg::BIT_COUNT_ONE;
                end
                if (sclRise && state_q == S_READ)
                begin
                    bitCnt_q <= bitCnt_q + fcf_pkg::BIT_COUNT_ONE;
                end
                if (sclRise && state_q == S_READ_ACK)
                begin
                    masterAck_q <= ~sdaIn; // low means another byte wanted
                end
                if (sclFall)
                begin
                    case (state_q)
                        S_ADDR:
                        begin
                            if (byteFull && shift_q[7:1] == chipAddr)
                            begin
                                readMode_q <= shift_q[0]; // see RULE6
                                sdaOe_q <= 1'b1; // acknowledge
                                state_q <= S_ADDR_ACK;
                            end
                            else if (byteFull)
                            begin
                                state_q <= S_IDLE; // not our address
                            end
                        end
                        S_ADDR_ACK:
                        begin
                            bitCnt_q <= fcf_pkg::BIT_COUNT_ZERO;
                            if (readMode_q)
                            begin
                                tx_q <= readByte;
                                sdaOe_q <= ~readByte[7]; // first data bit
                                state_q <= S_READ;
                            end
                            else
                            begin
                                sdaOe_q <= 1'b0;
                                state_q <= S_REG;
                            end
                        end
                        S_REG, S_WRITE:
                        begin
                            if (byteFull)
                            begin
                                sdaOe_q <= 1'b1; // ack register or data byte, see RULE6
                                state_q <= (state_q == S_REG) ? S_REG_ACK : S_WRITE_ACK;
                            end
                        end
                        S_REG_ACK, S_WRITE_ACK:
                        begin
                            bitCnt_q <= fcf_pkg::BIT_COUNT_ZERO;
                            sdaOe_q <= 1'b0;
                            state_q <= S_WRITE;
                        end
                        S_READ:
                        begin
                            if (byteFull)
                            begin
                                sdaOe_q <= 1'b0; // master acks now
                                state_q <= S_READ_ACK;
                            end
                            else
                            begin
                                sdaOe_q <= ~tx_q[txIdx];
                            end
                        end
                        S_READ_ACK:
                        begin
                            bitCnt_q <= fcf_pkg::BIT_COUNT_ZERO;
                            if (masterAck_q)
                            begin
                                tx_q <= readByte;
                                sdaOe_q <= ~readByte[7];
                                state_q <= S_READ;
                            end
                            else
                            begin
                                state_q <= S_IDLE; // master ended the read
                            end
                        end
                        default:
                        begin
                            state_q <= S_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // register pointer: set by register byte, steps after each written data byte and when each read byte is loaded
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_q <= fcf_pkg::BYTE_ZERO;
        end
        else if (clkEn)
        begin
            if (swReset)
            begin
                ptr_q <= fcf_pkg::BYTE_ZERO;
            end
            else if (state_q == S_REG && sclFall && byteFull && !startSeen && !stopSeen)
            begin
                ptr_q <= shift_q; // see RULE6
            end
            else if (writeStb || loadStb)
            begin
                ptr_q <= ptr_q + fcf_pkg::ADDR_STEP;
            end
        end
    end

    // fault response control register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= fcf_pkg::CTRL_RESET; // see RULE3
        end
        else if (clkEn)
        begin
            if (swReset)
            begin
                ctrl_q <= fcf_pkg::CTRL_RESET; // see RULE3
            end
            else if (writeStb && ptr_q == fcf_pkg::FAULT_CTRL_ADDR)
            begin
                ctrl_q <= shift_q[fcf_pkg::CTRL_WIDTH-1:0]; // upper bits dropped
            end
        end
    end

    // fault events feeding the flag store, short gated by its enable
    assign flagIf.detect[fcf_pkg::FLAG_OPEN] = openStringDetect;
    assign flagIf.detect[fcf_pkg::FLAG_SHORT] =
        ledShortDetect & ctrl_q[fcf_pkg::CTRL_SHORT_EN]; // see RULE1
    assign flagIf.detect[fcf_pkg::FLAG_THERMAL] = thermalTripDetect;
    assign flagIf.detect[fcf_pkg::FLAG_CURRENT] = overcurrentGuardDetect;
    assign flagIf.detect[fcf_pkg::FLAG_VOLTAGE] = overvoltageGuardDetect;
    assign flagIf.clearReq = loadStb && (ptr_q == fcf_pkg::FAULT_FLAGS_ADDR); // see RULE7
    assign flagIf.keep = ctrl_q[fcf_pkg::CTRL_SHORT_EN-1:0]; // shutdown keep bits

    fcf_flag_store #(
        .NUM_FLAGS(fcf_pkg::FLAG_WIDTH)
    ) uFlags (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .swReset(swReset),
        .flagIf(flagIf)
    );

    // outputs straight from flops, except sdaOut which is tied low
    assign sdaOut = 1'b0; // open drain, only ever pulls low
    assign sdaOe = sdaOe_q;
    assign shortDetectEnable = ctrl_q[fcf_pkg::CTRL_SHORT_EN]; // see RULE1
    assign forceShutdown = flagIf.shutdown; // latched in the flag store, see RULE2
    assign faultFlags = flagIf.flags;
endmodule // fcf_fault_bank
`default_nettype wire

// ===== test/fcf_fault_bank_asserts.sv
// checker for the fault control and flag register bank
`timescale 1ns/1ps
`default_nettype none
module fcf_fault_bank_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic swReset,
    input wire logic [6:0] chipAddr,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic openStringDetect,
    input wire logic ledShortDetect,
    input wire logic thermalTripDetect,
    input wire logic overcurrentGuardDetect,
    input wire logic overvoltageGuardDetect,
    input wire logic shortDetectEnable,
    input wire logic forceShutdown,
    input wire logic [4:0] faultFlags
);
    // events that must show up in the flags one edge later
    wire logic [4:0] mustSet = {openStringDetect, ledShortDetect & shortDetectEnable,
        thermalTripDetect, overcurrentGuardDetect, overvoltageGuardDetect};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // running and no flag held
    sequence calmState;
        !forceShutdown ##0 faultFlags == 5'h00;
    endsequence
    // pull-down kept for three more clocks
    sequence pullHeld;
        sdaOe [*3];
    endsequence
    chk_flag_set: assert property (clkEn && !swReset
        |=> (faultFlags & $past(mustSet)) == $past(mustSet))
        else $error("fault event not flagged");
    chk_short_gated: assert property (!shortDetectEnable && !faultFlags[3]
        && !swReset |=> !faultFlags[3])
        else $error("short flagged while detection off");
    chk_shutdown_cause: assert property (calmState |=> !forceShutdown)
        else $error("shutdown without a flag");
    chk_shutdown_latched: assert property (forceShutdown && !swReset
        |=> forceShutdown)
        else $error("shutdown dropped without reset");
    chk_flag_sticky: assert property (($past(faultFlags) & ~faultFlags) != 5'h00
        && !$past(swReset) |-> $past(sdaOe))
        else $error("flag cleared without a status read");
    chk_swreset_clear: assert property (swReset && clkEn
        |=> faultFlags == 5'h00 && !forceShutdown && !shortDetectEnable)
        else $error("software reset left state behind");
    chk_ack_hold: assert property (@(posedge clock)
        disable iff (!rst_n || swReset) $rose(sdaOe) |=> pullHeld)
        else $error("sda pull released too early");
    chk_drive_low: assert property (sdaOut == 1'b0)
        else $error("sda driven high");
endmodule // fcf_fault_bank_asserts
bind fcf_fault_bank fcf_fault_bank_asserts u_fcf_fault_bank_asserts (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .swReset(swReset), .chipAddr(chipAddr),
    .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .openStringDetect(openStringDetect), .ledShortDetect(ledShortDetect),
    .thermalTripDetect(thermalTripDetect), .overcurrentGuardDetect(overcurrentGuardDetect),
    .overvoltageGuardDetect(overvoltageGuardDetect), .shortDetectEnable(shortDetectEnable),
    .forceShutdown(forceShutdown), .faultFlags(faultFlags)
);
`default_nettype wire

// ===== test/fcf_host_model.sv
// host model: two-wire bus master reaching the fault registers
`timescale 1ns/1ps
`default_nettype none
module fcf_host_model #(
    parameter logic [6:0] CHIP = 7'h36 // arbitrary bus address
) (
    input wire logic clock,
    input wire logic sdaOe,
    output logic scl,
    output wire logic sdaIn
);
    logic mSda = 1'b1; // master drive, 1 = released
    // open drain with pull-up
    assign sdaIn = mSda & ~sdaOe;
    initial scl = 1'b1;
    // wait whole clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // one bit, sda moved only while scl low, sampled late in high phase
    task automatic xbit(input logic b, output logic r);
        mSda <= b;
        tick(2);
        scl <= 1'b1;
        tick(3);
        r = sdaIn;
        scl <= 1'b0;
        tick(2);
    endtask
    // eight bits msb first plus ninth bit
    task automatic xbyte(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
        output logic r9);
        for (int i = 7; i >= 0; i--)
            xbit(tx[i], rx[i]);
        xbit(ninth, r9);
    endtask
    // start, also repeated start
    task automatic begin_frame();
        mSda <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(3);
        mSda <= 1'b0;
        tick(3);
        scl <= 1'b0;
        tick(2);
    endtask
    // stop
    task automatic end_frame();
        mSda <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(3);
        mSda <= 1'b1;
        tick(3);
    endtask
    // address+W, register, data; ok when all three acked
    task automatic writeReg(input logic [6:0] dev, input logic [7:0] reg_, input logic [7:0] d,
        output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        begin_frame();
        xbyte({dev, 1'b0}, 1'b1, rx, a0);
        xbyte(reg_, 1'b1, rx, a1);
        xbyte(d, 1'b1, rx, a2);
        end_frame();
        ok = (a0 | a1 | a2) === 1'b0;
    endtask
    // pointer set, repeated start, one byte read then nack
    task automatic readReg(input logic [7:0] reg_, output logic [7:0] d);
        logic [7:0] rx;
        logic a;
        begin_frame();
        xbyte({CHIP, 1'b0}, 1'b1, rx, a);
        xbyte(reg_, 1'b1, rx, a);
        begin_frame();
        xbyte({CHIP, 1'b1}, 1'b1, rx, a);
        xbyte(8'hFF, 1'b1, d, a);
        end_frame();
    endtask
endmodule // fcf_host_model
`default_nettype wire

// ===== test/test_fault_control_and_flags.sv
// self-checking bench for the fault control and flag register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) cmp(n, e, g)
module test_fault_control_and_flags;
    localparam logic [6:0] CHIP = 7'h36; // arbitrary bus address
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic swReset = 1'b0;
    logic [4:0] det = 5'h00; // {open,short,thermal,current,voltage}
    logic [7:0] rd;
    logic ok;
    wire logic scl;
    wire logic sdaIn;
    wire logic sdaOe;
    wire logic shortDetectEnable;
    wire logic forceShutdown;
    wire logic [4:0] faultFlags;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    always #2 clock = ~clock;
    fcf_fault_bank u_fcf_fault_bank (.clock(clock), .rst_n(rst_n), .clkEn(1'b1),
        .swReset(swReset), .chipAddr(CHIP), .scl(scl), .sdaIn(sdaIn), .sdaOut(),
        .sdaOe(sdaOe), .openStringDetect(det[4]), .ledShortDetect(det[3]),
        .thermalTripDetect(det[2]), .overcurrentGuardDetect(det[1]),
        .overvoltageGuardDetect(det[0]), .shortDetectEnable(shortDetectEnable),
        .forceShutdown(forceShutdown), .faultFlags(faultFlags));
    fcf_host_model #(.CHIP(CHIP)) u_fcf_host_model (.clock(clock), .sdaOe(sdaOe),
        .scl(scl), .sdaIn(sdaIn));
    // compare and count
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    // verdict and end of run
    task automatic final_report();
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one-cycle fault events, then room for flag and shutdown
    task automatic pulse(input logic [4:0] m);
        @(posedge clock) det <= m;
        @(posedge clock) det <= 5'h00;
        repeat (3) @(posedge clock);
    endtask
    // software reset for one cycle
    task automatic soft_reset();
        @(posedge clock) swReset <= 1'b1;
        @(posedge clock) swReset <= 1'b0;
        @(posedge clock);
    endtask
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end
    // main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        u_fcf_host_model.readReg(8'h1E, rd);
        `CHK("ctrl reset", 8'h07, rd);
        `CHK("short enable reset", 8'h00, {7'h00, shortDetectEnable});
        pulse(5'h1F);
        `CHK("flags keep on", 8'h17, {3'h0, faultFlags});
        `CHK("no shutdown", 8'h00, {7'h00, forceShutdown});
        u_fcf_host_model.readReg(8'h1F, rd);
        `CHK("status read", 8'h17, rd);
        `CHK("flags cleared", 8'h00, {3'h0, faultFlags});
        u_fcf_host_model.readReg(8'h1F, rd);
        `CHK("status after clear", 8'h00, rd);
        u_fcf_host_model.writeReg(CHIP, 8'h1E, 8'hFF, ok);
        `CHK("write acked", 8'h01, {7'h00, ok});
        u_fcf_host_model.readReg(8'h1E, rd);
        `CHK("ctrl reserved", 8'h0F, rd);
        `CHK("short enable on", 8'h01, {7'h00, shortDetectEnable});
        pulse(5'h08);
        u_fcf_host_model.writeReg(CHIP, 8'h1F, 8'hFF, ok);
        u_fcf_host_model.readReg(8'h1F, rd);
        `CHK("short flag held", 8'h08, rd);
        u_fcf_host_model.writeReg(CHIP ^ 7'h01, 8'h1E, 8'h00, ok);
        `CHK("foreign address", 8'h00, {7'h00, ok});
        u_fcf_host_model.readReg(8'h1E, rd);
        `CHK("ctrl untouched", 8'h0F, rd);
        // each keep bit cleared in turn
        for (int i = 0; i < 3; i++)
        begin
            u_fcf_host_model.writeReg(CHIP, 8'h1E, 8'h07 & ~(8'h01 << i), ok);
            pulse(5'h07 & ~(5'h01 << i));
            `CHK("other fault runs on", 8'h00, {7'h00, forceShutdown});
            pulse(5'h01 << i);
            `CHK("own fault stops", 8'h01, {7'h00, forceShutdown});
            soft_reset();
            `CHK("reset restart", 8'h00, {7'h00, forceShutdown});
            u_fcf_host_model.readReg(8'h1E, rd);
            `CHK("ctrl back", 8'h07, rd);
        end
        // open string shares the voltage keep bit
        u_fcf_host_model.writeReg(CHIP, 8'h1E, 8'h06, ok);
        pulse(5'h10);
        `CHK("open string stops", 8'h01, {7'h00, forceShutdown});
        final_report();
    end
endmodule // test_fault_control_and_flags
`default_nettype wire
